// [swi_host_model.sv]
// Host-side model: ready pin driver, pulled-up interrupt wire and sensor-driven GPIO wires
`timescale 1ns/1ps
module swi_host_model (
    input  wire logic       core_clk_i,   // Bench clock
    input  wire logic       ready_req_i,  // Ready level wanted by bench
    input  wire logic       irq_i,        // Device interrupt level
    input  wire logic       irq_oe_n_i,   // Device interrupt enable, low
    input  wire logic [1:0] gpio_i,       // Device GPIO levels
    input  wire logic [1:0] gpio_oe_n_i,  // Device GPIO enables, low
    input  wire logic [1:0] gpio_ext_i,   // Sensor levels from bench
    output logic            ready_o,      // Host ready pin
    output logic            irq_n_pin_o,  // Interrupt wire, active low
    output logic      [1:0] gpio_pin_o    // Resolved GPIO wires
);
    assign irq_n_pin_o = irq_oe_n_i ? 1'b1 : irq_i;
    // Sensor drives a pin only while the device lets go of it
    assign gpio_pin_o[0] = gpio_oe_n_i[0] ? gpio_ext_i[0] : gpio_i[0];
    assign gpio_pin_o[1] = gpio_oe_n_i[1] ? gpio_ext_i[1] : gpio_i[1];
    // Host moves its ready pin one clock after the bench asks
    always_ff @(posedge core_clk_i) begin
        ready_o <= ready_req_i;
    end
endmodule

// [swi_pkg.sv]
// Constants shared by the standby, wake and interrupt control block
package swi_pkg;
    // Register bus widths
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [4:0] OFS_IRQ_BUF  = 5'h00;
    localparam logic [4:0] OFS_KEY_DATA = 5'h01;
    localparam logic [4:0] OFS_IR_DATA  = 5'h02;
    localparam logic [4:0] OFS_GPIO_IN  = 5'h03;
    localparam logic [4:0] OFS_CTRL     = 5'h04;
    localparam logic [4:0] OFS_STATE    = 5'h05;
    localparam logic [4:0] OFS_HK_AEN   = 5'h06;
    localparam logic [4:0] OFS_HK_CEN   = 5'h07;
    localparam logic [4:0] OFS_HK_ADDR  = 5'h08;
    localparam logic [4:0] OFS_HK_CMD   = 5'h10;

    // Hotkey memory sizes
    localparam int HK_NADDR = 8;
    localparam int HK_NCMD  = 16;

    // Interrupt source bit positions
    localparam int SRC_KEY   = 0;
    localparam int SRC_IR    = 1;
    localparam int SRC_WAKE  = 2;
    localparam int SRC_ALARM = 3;
    localparam int SRC_WDOG  = 4;
    localparam int SRC_OSC   = 5;
    localparam int SRC_GPIO  = 6;
    localparam int SRC_BATT  = 7;
    localparam int SRC_THERM = 8;
    localparam int NSRC      = 9;

    // Control register fields
    localparam int CTL_AFE     = 0;
    localparam int CTL_ABE     = 1;
    localparam int CTL_PROTO_L = 2;
    localparam int CTL_GUARD   = 5;
    localparam int CTL_DIR_L   = 6;
    localparam int CTL_OUT_L   = 8;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;

    // Ready-to-standby delay
    localparam int CLK_NS       = 25;
    localparam int STANDBY_OUT_DLY_NS  = 2000;
    localparam int STANDBY_OUT_DLY_CYC = (STANDBY_OUT_DLY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] STANDBY_OUT_LAST = 7'(STANDBY_OUT_DLY_CYC - 1);

    // Power sequencing states
    typedef enum logic [1:0] {
        ST_BOOT,
        ST_NORM,
        ST_MUTE,
        ST_STANDBY_OUT
    } swi_state_t;
endpackage

// [swi_top.sv]
// Standby sequencing, wake sources and interrupt gathering
`timescale 1ns/1ps
module swi_top (
    input  wire logic        core_clk_i,     // 40 MHz clock
    input  wire logic        rstn_i,         // Async reset, active low
    input  wire logic [4:0]  reg_addr_i,     // Register address
    input  wire logic [15:0] reg_wdata_i,    // Write data
    input  wire logic        reg_we_i,       // Write strobe
    input  wire logic        reg_re_i,       // Read strobe
    output logic      [15:0] reg_rdata_o,    // Read data, next cycle
    input  wire logic        key_evt_i,      // Key scan press pulse
    input  wire logic [7:0]  key_code_i,     // Pressed key code
    input  wire logic        ir_valid_i,     // Decoded remote frame
    input  wire logic [7:0]  ir_addr_i,      // Remote device address
    input  wire logic [7:0]  ir_cmd_i,       // Remote command
    input  wire logic        ir_toggle_i,    // Remote toggle bit
    output logic      [2:0]  ir_proto_o,     // Protocol select
    input  wire logic        wake_pin_i,     // External wake pin
    input  wire logic        alarm_match_i,  // Clock alarm match
    input  wire logic        wdog_exp_i,     // Watchdog expiry
    input  wire logic        osc_fail_i,     // 32 kHz osc failure
    input  wire logic        batt_check_i,   // Battery check pulse
    input  wire logic        batt_low_i,     // Battery below limit
    input  wire logic        therm_shdn_i,   // Thermal shutdown
    input  wire logic        ready_i,        // Host ready pin
    input  wire logic        guard_zero_i,   // Guard timer at zero
    output logic             guard_en_o,     // Guard timer enable
    output logic             standby_out_o,  // Standby to supply
    output logic             mute_o,         // Audio mute
    output logic             wake_start_o,   // Hotkey wake pulse
    output logic             irq_o,          // Interrupt pin level
    output logic             irq_oe_n_o,     // Interrupt pin enable
    input  wire logic [1:0]  gpio_i,         // GPIO pin inputs
    output logic      [1:0]  gpio_o,         // GPIO pin outputs
    output logic      [1:0]  gpio_oe_n_o     // GPIO enables, low
);

    // Reset release pair
    logic [1:0] rst_q;
    logic       rst_n;

    // Release reset through two flops
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Pin synchronisers: ready, wake, two gpio
    logic [3:0] s1_q, s2_q, s3_q;   // Three flop chain
    logic [3:0] flt_q;              // Agreed level
    logic [3:0] flt_p_q;            // Previous agreed level
    logic [3:0] pin_raw;

    assign pin_raw = {gpio_i, wake_pin_i, ready_i};

    // Three flops; level accepted once second and third agree
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= 4'h0;
            s2_q    <= 4'h0;
            s3_q    <= 4'h0;
            flt_q   <= 4'h0;
            flt_p_q <= 4'h0;
        end else begin
            s1_q    <= pin_raw;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            flt_q   <= (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
            flt_p_q <= flt_q;
        end
    end

    // Synced edges
    logic ready_f, ready_fall, wake_rise;
    logic [1:0] gpio_in;
    assign ready_f    = flt_q[0];
    assign ready_fall = flt_p_q[0] & ~flt_q[0];
    assign wake_rise  = flt_q[1] & ~flt_p_q[1];
    assign gpio_in    = flt_q[3:2];

    // Software registers
    logic [15:0] ctrl_q;                       // Control
    logic [7:0]  hk_aen_q;                     // Address slot enables
    logic [15:0] hk_cen_q;                     // Command slot enables
    logic [7:0]  hk_addr_q [swi_pkg::HK_NADDR]; // Device addresses
    logic [7:0]  hk_cmd_q  [swi_pkg::HK_NCMD];  // Hotkey commands
    logic [7:0]  key_data_q;                   // Last key code
    logic [15:0] ir_data_q;                    // Last remote frame
    logic        alarm_flag_q;                 // Alarm flag
    logic [swi_pkg::NSRC-1:0] pend_q;          // Pending sources
    logic [15:0] rdata_q;

    // Access decode
    logic wr_ctrl, wr_aen, wr_cen, wr_hka, wr_hkc, buf_rd;
    assign wr_ctrl = reg_we_i && (reg_addr_i == swi_pkg::OFS_CTRL);
    assign wr_aen  = reg_we_i && (reg_addr_i == swi_pkg::OFS_HK_AEN);
    assign wr_cen  = reg_we_i && (reg_addr_i == swi_pkg::OFS_HK_CEN);
    assign wr_hka  = reg_we_i && (reg_addr_i[4:3] == 2'h1);
    assign wr_hkc  = reg_we_i && reg_addr_i[4];
    assign buf_rd  = reg_re_i && (reg_addr_i == swi_pkg::OFS_IRQ_BUF);

    // Control fields
    logic afe, abe;
    assign afe = ctrl_q[swi_pkg::CTL_AFE];
    assign abe = ctrl_q[swi_pkg::CTL_ABE];

    // Control and enable registers
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= swi_pkg::CTRL_RST;
            hk_aen_q <= 8'h00;
            hk_cen_q <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i;
            end
            if (wr_aen) begin
                hk_aen_q <= reg_wdata_i[7:0];
            end
            if (wr_cen) begin
                hk_cen_q <= reg_wdata_i;
            end
        end
    end

    // Hotkey memory, one byte per slot
    always_ff @(posedge core_clk_i) begin
        if (wr_hka) begin
            hk_addr_q[reg_addr_i[2:0]] <= reg_wdata_i[7:0];
        end
        if (wr_hkc) begin
            hk_cmd_q[reg_addr_i[3:0]] <= reg_wdata_i[7:0];
        end
    end

    // Hotkey compare against every enabled slot
    logic [swi_pkg::HK_NADDR-1:0] a_hit;
    logic [swi_pkg::HK_NCMD-1:0]  c_hit;
    logic                         hk_hit;
    genvar g;
    generate
        for (g = 0; g < swi_pkg::HK_NADDR; g++) begin : g_addr
            assign a_hit[g] = hk_aen_q[g] && (hk_addr_q[g] == ir_addr_i);
        end
        for (g = 0; g < swi_pkg::HK_NCMD; g++) begin : g_cmd
            assign c_hit[g] = hk_cen_q[g] && (hk_cmd_q[g] == ir_cmd_i);
        end
    endgenerate
    assign hk_hit = ir_valid_i && (|a_hit) && (|c_hit);

    // Source events of this cycle
    logic [1:0] gpio_chg;
    logic [swi_pkg::NSRC-1:0] evt;
    assign gpio_chg = (gpio_in ^ flt_p_q[3:2]) & ~ctrl_q[7:6];

    // key press, held off during buffer read
    assign evt[swi_pkg::SRC_KEY]   = key_evt_i && !buf_rd;
    assign evt[swi_pkg::SRC_IR]    = ir_valid_i;
    assign evt[swi_pkg::SRC_WAKE]  = wake_rise;
    assign evt[swi_pkg::SRC_ALARM] = alarm_match_i && afe;
    assign evt[swi_pkg::SRC_WDOG]  = wdog_exp_i;
    assign evt[swi_pkg::SRC_OSC]   = osc_fail_i;
    assign evt[swi_pkg::SRC_GPIO]  = (|gpio_chg) && !buf_rd;
    // battery low on each enabled check
    assign evt[swi_pkg::SRC_BATT]  = batt_check_i && batt_low_i && abe;
    assign evt[swi_pkg::SRC_THERM] = therm_shdn_i;

    // Pending flags: buffer read clears, new event wins
    logic [swi_pkg::NSRC-1:0] pend_d;
    assign pend_d = (pend_q & ~(buf_rd ? pend_q : '0)) | evt;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_q       <= '0;
            alarm_flag_q <= 1'b0;
        end else begin
            pend_q       <= pend_d;
            alarm_flag_q <= alarm_match_i | (alarm_flag_q & ~buf_rd);
        end
    end

    // data registers always take new values
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            key_data_q <= 8'h00;
            ir_data_q  <= 16'h0000;
        end else begin
            if (key_evt_i) begin
                key_data_q <= key_code_i;
            end
            if (ir_valid_i) begin
                ir_data_q <= {ir_addr_i[7:1], ir_toggle_i, ir_cmd_i};
            end
        end
    end

    // Power sequencing
    swi_pkg::swi_state_t st_q, st_d;
    logic [6:0] dly_q;               // Mute to standby count
    logic       standby_out_wake;           // Wake request in standby
    logic       guard_trip;          // Guard timer expired
    logic       standby_q, mute_q, wake_q;

    assign standby_out_wake  = hk_hit | key_evt_i | wake_rise | alarm_match_i;
    assign guard_trip = ctrl_q[swi_pkg::CTL_GUARD] && guard_zero_i;

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            // boot: ready high goes normal, else guard
            swi_pkg::ST_BOOT: begin
                if (ready_f) begin
                    st_d = swi_pkg::ST_NORM;
                end else if (guard_zero_i) begin
                    st_d = swi_pkg::ST_STANDBY_OUT;
                end
            end
            swi_pkg::ST_NORM: begin
                if (ready_fall) begin
                    st_d = swi_pkg::ST_MUTE;
                end else if (guard_trip) begin
                    st_d = swi_pkg::ST_STANDBY_OUT;
                end
            end
            swi_pkg::ST_MUTE: begin
                if (dly_q == swi_pkg::STANDBY_OUT_LAST) begin
                    st_d = swi_pkg::ST_STANDBY_OUT;
                end
            end
            // wake on hotkey or other wake source
            default: begin
                if (standby_out_wake) begin
                    st_d = swi_pkg::ST_BOOT;
                end
            end
        endcase
    end

    // State, delay counter and sequencing outputs
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= swi_pkg::ST_BOOT;
            dly_q     <= 7'h00;
            standby_q <= 1'b0;
            mute_q    <= 1'b1;
            wake_q    <= 1'b0;
        end else begin
            st_q      <= st_d;
            dly_q     <= (st_q == swi_pkg::ST_MUTE) ? dly_q + 7'h01 : 7'h00;
            standby_q <= (st_d == swi_pkg::ST_STANDBY_OUT);
            mute_q    <= ~ready_f;
            wake_q    <= hk_hit && (st_q == swi_pkg::ST_STANDBY_OUT);
        end
    end

    // Read mux
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        if (reg_addr_i == swi_pkg::OFS_IRQ_BUF) begin
            rd_mux = {7'h00, pend_q};
        end else if (reg_addr_i == swi_pkg::OFS_KEY_DATA) begin
            rd_mux = {8'h00, key_data_q};
        end else if (reg_addr_i == swi_pkg::OFS_IR_DATA) begin
            rd_mux = ir_data_q;
        end else if (reg_addr_i == swi_pkg::OFS_GPIO_IN) begin
            rd_mux = {14'h0000, gpio_in};
        end else if (reg_addr_i == swi_pkg::OFS_CTRL) begin
            rd_mux = ctrl_q;
        end else if (reg_addr_i == swi_pkg::OFS_STATE) begin
            rd_mux = {10'h000, alarm_flag_q, ready_f, mute_q,
                      standby_q, 2'(st_q)};
        end else if (reg_addr_i == swi_pkg::OFS_HK_AEN) begin
            rd_mux = {8'h00, hk_aen_q};
        end else if (reg_addr_i == swi_pkg::OFS_HK_CEN) begin
            rd_mux = hk_cen_q;
        end else if (reg_addr_i[4:3] == 2'h1) begin
            rd_mux = {8'h00, hk_addr_q[reg_addr_i[2:0]]};
        end else if (reg_addr_i[4]) begin
            rd_mux = {8'h00, hk_cmd_q[reg_addr_i[3:0]]};
        end
    end

    // Read data register
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= reg_re_i ? rd_mux : 16'h0000;
        end
    end

    // Outputs
    assign reg_rdata_o   = rdata_q;
    assign ir_proto_o    = ctrl_q[4:2];
    assign guard_en_o    = ctrl_q[swi_pkg::CTL_GUARD];
    assign standby_out_o = standby_q;
    assign mute_o        = mute_q;
    assign wake_start_o  = wake_q;
    // pull low only; level while pending
    assign irq_o         = 1'b0;
    assign irq_oe_n_o    = ~(|pend_q);
    // direction and output level per pin
    assign gpio_o        = ctrl_q[9:8];
    assign gpio_oe_n_o   = ~ctrl_q[7:6];

    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_fall;
        (st_q == swi_pkg::ST_NORM) && ready_fall;
    endsequence
    sequence s_mute_on;
        mute_q && !standby_q;
    endsequence

    AST_KEY_IRQ: assert property (key_evt_i && !buf_rd |=> !irq_oe_n_o)
        else $error("Key press did not raise interrupt");
    AST_IR_IRQ: assert property (ir_valid_i |=> !irq_oe_n_o)
        else $error("Remote frame did not raise interrupt");
    AST_WAKE_IRQ: assert property (wake_rise |=> pend_q[2])
        else $error("Wake pin rise not pending");
    AST_RTC_IRQ: assert property (wdog_exp_i || osc_fail_i |=> !irq_oe_n_o)
        else $error("Clock event did not raise interrupt");
    AST_HOLD: assert property (!irq_oe_n_o && !buf_rd |=> !irq_oe_n_o)
        else $error("Interrupt dropped without buffer read");
    AST_BUF_SRC: assert property (buf_rd && pend_q[0] |=> reg_rdata_o[0])
        else $error("Buffer read lost key source");
    AST_PIN_LOW: assert property (irq_o == 1'b0)
        else $error("Interrupt pin driven high");
    AST_NO_KEY_IRQ: assert property (buf_rd && key_evt_i |=> !pend_q[0]
        && key_data_q == $past(key_code_i))
        else $error("Key during read mishandled");
    AST_STANDBY_OUT_LATE: assert property ($rose(standby_q)
        && $past(st_q) == swi_pkg::ST_MUTE |-> $past(mute_q, 80))
        else $error("Standby came before 2us after mute");
    AST_SEQ: assert property (s_fall |=> s_mute_on ##1 s_mute_on)
        else $error("Mute did not lead standby");
    AST_GUARD: assert property ((st_q == swi_pkg::ST_NORM) && !ready_fall
        && !guard_trip |=> !standby_q)
        else $error("Standby without guard expiry");
    AST_MUTE_INV: assert property (##1 mute_q == !$past(ready_f))
        else $error("Mute not inverted ready");
    AST_HOTKEY: assert property ((st_q == swi_pkg::ST_STANDBY_OUT) && hk_hit
        |=> wake_start_o && st_q == swi_pkg::ST_BOOT)
        else $error("Hotkey did not start wake");
    AST_ALARM_EN: assert property (alarm_match_i && !afe && !pend_q[3]
        |=> !pend_q[3] && alarm_flag_q)
        else $error("Alarm enable gating wrong");

endmodule

// [swi_top_test.sv]
// Self-checking bench for the standby, wake and interrupt block
`timescale 1ns/1ps
module swi_top_test;
    logic        core_clk, rstn, we, re, re_seen, batt_low, ready_req;
    logic        ready, guard_zero, guard_en, standby_out, mute, wake_start;
    logic        irq, irq_oe_n, irq_pin, ir_tog;
    logic [8:0]  ev;          // Event pulses by source bit, one cycle, three cycles for wake
    logic [4:0]  addr;
    logic [15:0] wdata, rdata;
    logic [7:0]  key_code, ir_addr, ir_cmd, lfsr, hk_a, hk_c;
    logic [2:0]  ir_proto;
    logic [1:0]  gpio_ext, gpio_o, gpio_oe_n, gpio_pin;
    logic [15:0] exp_q[$];    // Expected read data, oldest first
    int          errors, checks_done, waited;

    swi_top dut (
        .core_clk_i(core_clk), .rstn_i(rstn), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .key_evt_i(ev[swi_pkg::SRC_KEY]),
        .key_code_i(key_code), .ir_valid_i(ev[swi_pkg::SRC_IR]),
        .ir_addr_i(ir_addr), .ir_cmd_i(ir_cmd), .ir_toggle_i(ir_tog),
        .ir_proto_o(ir_proto), .wake_pin_i(ev[swi_pkg::SRC_WAKE]),
        .alarm_match_i(ev[swi_pkg::SRC_ALARM]),
        .wdog_exp_i(ev[swi_pkg::SRC_WDOG]),
        .osc_fail_i(ev[swi_pkg::SRC_OSC]),
        .batt_check_i(ev[swi_pkg::SRC_BATT]), .batt_low_i(batt_low),
        .therm_shdn_i(ev[swi_pkg::SRC_THERM]), .ready_i(ready),
        .guard_zero_i(guard_zero), .guard_en_o(guard_en),
        .standby_out_o(standby_out), .mute_o(mute), .wake_start_o(wake_start),
        .irq_o(irq), .irq_oe_n_o(irq_oe_n), .gpio_i(gpio_pin),
        .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n));

    swi_host_model host (
        .core_clk_i(core_clk), .ready_req_i(ready_req), .irq_i(irq),
        .irq_oe_n_i(irq_oe_n), .gpio_i(gpio_o), .gpio_oe_n_i(gpio_oe_n),
        .gpio_ext_i(gpio_ext), .ready_o(ready), .irq_n_pin_o(irq_pin),
        .gpio_pin_o(gpio_pin));

    // Clock at 40 MHz
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Pseudo-random byte step
    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen,
                     want);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge core_clk);
        we <= 1'b0;
    endtask

    // Read with an optional event pulse in the same cycle
    task automatic rd_evt(input logic [4:0] a, input logic [8:0] e,
                          input logic [15:0] want);
        @(posedge core_clk);
        addr <= a;
        re <= 1'b1;
        ev <= e;
        exp_q.push_back(want);
        @(posedge core_clk);
        re <= 1'b0;
        ev <= '0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] want);
        rd_evt(a, 9'h000, want);
    endtask

    // One event pulse; the GPIO source toggles the sensor levels
    task automatic fire(input int s);
        @(posedge core_clk);
        if (s == swi_pkg::SRC_GPIO) begin
            gpio_ext <= ~gpio_ext;
        end else begin
            ev <= 9'(1 << s);
        end
        // The wake pin must outlast the three-flop filter
        repeat ((s == swi_pkg::SRC_WAKE) ? 3 : 1) @(posedge core_clk);
        ev <= '0;
    endtask

    function automatic logic probe(input int s);
        case (s)
            0: return irq_pin;
            1: return mute;
            2: return standby_out;
            default: return wake_start;
        endcase
    endfunction

    // Bounded wait for a watched output to reach a level
    task automatic await(input int s, input logic lvl, input int lim);
        waited = 0;
        // Look once outputs launched at the last edge have settled
        #1;
        while (probe(s) !== lvl && waited < lim) begin
            @(posedge core_clk);
            #1;
            waited++;
        end
        check(16'(probe(s)), 16'(lvl));
    endtask

    // Compare read data against the oldest note
    always @(posedge core_clk) re_seen <= re;
    always @(negedge core_clk) begin
        if (re_seen === 1'b1 && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end
    end

    // Watchdog against a hang
    initial begin
        #(25 * 20000);
        errors++;
        give_verdict();
    end

    initial begin
        {rstn, we, re, ev, addr, wdata, ready_req, guard_zero} = '0;
        {key_code, ir_addr, ir_cmd, ir_tog, gpio_ext} = '0;
        {errors, checks_done} = '0;
        batt_low = 1'b1;
        lfsr = 8'h44;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check({irq_pin, mute, standby_out, gpio_oe_n}, 16'h001B);
        rd(swi_pkg::OFS_CTRL, swi_pkg::CTRL_RST);
        ready_req <= 1'b1;
        await(1, 1'b0, 20);
        // Alarm and battery stay quiet with their enables clear
        fire(swi_pkg::SRC_ALARM);
        fire(swi_pkg::SRC_BATT);
        repeat (6) @(posedge core_clk);
        #1;
        check(16'(irq_pin), 16'h0001);
        rd(swi_pkg::OFS_IRQ_BUF, 16'h0000);
        // protocol select follows the control field; guard timer stays off
        for (int p = 0; p < 6; p++) begin
            wr(swi_pkg::OFS_CTRL, 16'(p << swi_pkg::CTL_PROTO_L) | 16'h3);
            #1;
            check(16'(ir_proto), 16'(p));
        end
        for (int s = 0; s < swi_pkg::NSRC; s++) begin
            lfsr = next_rand(lfsr);
            key_code <= lfsr;
            ir_addr <= ~lfsr;
            ir_cmd <= lfsr ^ 8'h5A;
            ir_tog <= lfsr[2];
            fire(s);
            await(0, 1'b0, 10);
            repeat (5) @(posedge core_clk);
            #1;
            check(16'(irq_pin), 16'h0000);
            if (s == swi_pkg::SRC_KEY) begin
                rd(swi_pkg::OFS_KEY_DATA, {8'h00, key_code});
            end
            if (s == swi_pkg::SRC_IR) begin
                rd(swi_pkg::OFS_IR_DATA,
                   {ir_addr[7:1], ir_tog, ir_cmd});
            end
            rd(swi_pkg::OFS_IRQ_BUF, 16'(1 << s));
            await(0, 1'b1, 4);
        end
        // Key arriving during the buffer read: data only, no interrupt
        fire(swi_pkg::SRC_WDOG);
        lfsr = next_rand(lfsr);
        key_code <= lfsr;
        rd_evt(swi_pkg::OFS_IRQ_BUF, 9'h001, 16'h0010);
        await(0, 1'b1, 4);
        rd(swi_pkg::OFS_KEY_DATA, {8'h00, lfsr});
        // Event during the read stays pending and holds the line
        fire(swi_pkg::SRC_OSC);
        rd_evt(swi_pkg::OFS_IRQ_BUF, 9'h100, 16'h0020);
        repeat (3) @(posedge core_clk);
        #1;
        check(16'(irq_pin), 16'h0000);
        rd(swi_pkg::OFS_IRQ_BUF, 16'h0100);
        await(0, 1'b1, 4);
        // Pin 0 drives low against a high sensor, pin 1 stays input
        wr(swi_pkg::OFS_CTRL, 16'h0043);
        #1;
        check({12'h0, gpio_oe_n, gpio_pin[0], 1'b0}, 16'h0008);
        // Hotkey: device address first, then the command
        hk_a = next_rand(lfsr);
        hk_c = next_rand(hk_a);
        wr(swi_pkg::OFS_HK_ADDR + 5'h7, {8'h00, hk_a});
        wr(swi_pkg::OFS_HK_CMD + 5'h3, {8'h00, hk_c});
        wr(swi_pkg::OFS_HK_AEN, 16'h0080);
        wr(swi_pkg::OFS_HK_CEN, 16'h0008);
        ready_req <= 1'b0;
        await(1, 1'b1, 10);
        await(2, 1'b1, 200);
        check(16'(waited), 16'(swi_pkg::STANDBY_OUT_DLY_CYC));
        ir_addr <= hk_a;
        ir_cmd <= hk_c ^ 8'h01;
        fire(swi_pkg::SRC_IR);
        repeat (6) @(posedge core_clk);
        #1;
        check(16'(standby_out), 16'h0001);
        ir_cmd <= hk_c;
        fire(swi_pkg::SRC_IR);
        await(3, 1'b1, 6);
        await(2, 1'b0, 3);
        rd(swi_pkg::OFS_IRQ_BUF, 16'h0002);
        guard_zero <= 1'b1;
        await(2, 1'b1, 10);
        guard_zero <= 1'b0;
        fire(swi_pkg::SRC_KEY);
        await(2, 1'b0, 10);
        rd(swi_pkg::OFS_IRQ_BUF, 16'h0001);
        ready_req <= 1'b1;
        await(1, 1'b0, 10);
        guard_zero <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        check(16'(standby_out), 16'h0000);
        wr(swi_pkg::OFS_CTRL, 16'h0023);
        await(2, 1'b1, 5);
        check(16'(guard_en), 16'h0001);
        // Standby state, standby high, mute low, ready high
        rd(swi_pkg::OFS_STATE, 16'h0017);
        give_verdict();
    end
endmodule
